/* include/cell_in_pkg.sv */
package cell_in_pkg;
	localparam int WIDE_BITS = 16;
	localparam int NARROW_BITS = 8;
	localparam int CELL_WORDS_WIDE = 26;
	localparam int CELL_BYTES_NARROW = 52;
	localparam int CELL_CNT_BITS = 6;
	localparam int PORT_SEL_BITS = 5;
	localparam int REF_CLK_HZ = 10000000;
	// Half period of the link clock made by the master, in reference cycles.
	localparam int LINK_HALF_DIV = 4;
	localparam int LINK_DIV_BITS = 3;
	localparam int WIDE_MAX_CLK_MHZ = 33;
	localparam int NARROW_MAX_CLK_MHZ = 52;
	localparam logic [PORT_SEL_BITS-1:0] PORT_SEL_RESET = 5'h00;
	localparam logic [WIDE_BITS-1:0] WORD_RESET = 16'h0000;
endpackage

/* include/cell_in_if.sv */
`timescale 1ns/1ps
interface cell_in_if;
	logic cell_in_transfer_clock;
	logic [15:0] cell_in_word_bus;
	logic cell_in_parity_bit;
	logic cell_in_first_word_flag;
	logic cell_in_enable_low;
	logic [4:0] cell_in_port_select;
	modport master (
		output cell_in_transfer_clock,
		output cell_in_word_bus,
		output cell_in_parity_bit,
		output cell_in_first_word_flag,
		output cell_in_enable_low,
		output cell_in_port_select
	);
	modport phy (
		input cell_in_transfer_clock,
		input cell_in_word_bus,
		input cell_in_parity_bit,
		input cell_in_first_word_flag,
		input cell_in_enable_low,
		input cell_in_port_select
	);
endinterface

/* core/cell_in_master.sv */
`timescale 1ns/1ps
module cell_in_master
	import cell_in_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	cell_in_if.master link,
	input wire logic wide_mode,
	input wire logic odd_parity,
	input wire logic [PORT_SEL_BITS-1:0] port_select,
	input wire logic [WIDE_BITS-1:0] src_word,
	input wire logic src_first,
	input wire logic src_valid,
	output logic src_ready
);
	typedef struct packed {
		logic [LINK_DIV_BITS-1:0] div;
		logic lclk;
		logic [WIDE_BITS-1:0] word;
		logic par;
		logic soc;
		logic enb_n;
	} mst_t;
	mst_t q, d;
	logic fall_now;
	logic [WIDE_BITS-1:0] masked;
	assign fall_now = q.lclk && (q.div == LINK_DIV_BITS'(LINK_HALF_DIV - 1));
	// Source words are taken at the falling edge so they are stable at the rising edge.
	assign src_ready = clk_en && fall_now;
	always_comb begin
		masked = wide_mode ? src_word : {8'h00, src_word[NARROW_BITS-1:0]};
		d = q;
		if (clk_en) begin
			if (q.div == LINK_DIV_BITS'(LINK_HALF_DIV - 1)) begin
				d.div = '0;
				d.lclk = ~q.lclk;
			end else begin
				d.div = q.div + 1'b1;
			end
			if (fall_now) begin
				d.enb_n = ~src_valid;
				d.soc = src_valid && src_first;
				if (src_valid) begin
					d.word = masked;
					d.par = (^masked) ^ odd_parity;
				end
			end
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{div: '0, lclk: 1'b0, word: WORD_RESET, par: 1'b0, soc: 1'b0, enb_n: 1'b1};
		end else begin
			q <= d;
		end
	end
	assign link.cell_in_transfer_clock = q.lclk;
	assign link.cell_in_word_bus = q.word;
	assign link.cell_in_parity_bit = q.par;
	assign link.cell_in_first_word_flag = q.soc;
	assign link.cell_in_enable_low = q.enb_n;
	assign link.cell_in_port_select = port_select;
endmodule // cell_in_master

/* core/cell_in_phy.sv */
`timescale 1ns/1ps
module cell_in_phy
	import cell_in_pkg::*;
#(
	parameter int DEPTH = 2
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	cell_in_if.phy link,
	input wire logic wide_mode,
	input wire logic odd_parity,
	input wire logic [PORT_SEL_BITS-1:0] my_port,
	input wire logic parity_err_clear,
	output logic parity_err,
	output logic [WIDE_BITS-1:0] out_word,
	output logic out_first,
	output logic out_last,
	output logic out_valid,
	input wire logic out_ready,
	output logic overflow
);
	localparam int ENT = WIDE_BITS + 2;
	typedef struct packed {
		logic clk_old;
		logic in_cell;
		logic [CELL_CNT_BITS-1:0] cnt;
		logic perr;
		logic ovf;
	} phy_t;
	phy_t q, d;
	logic [WIDE_BITS-1:0] w;
	logic par;
	logic soc;
	logic enb_n;
	logic lclk;
	logic [PORT_SEL_BITS-1:0] sel;
	logic rise, take, start, last, push, room;
	logic [CELL_CNT_BITS-1:0] cell_len;
	logic [ENT-1:0] entry;
	logic [ENT-1:0] head;
	// Every link pin passes two flip-flops; the rise is found behind the second stage.
	cell_in_sync #(.W(1)) clk_sync (
		.ref_clk,
		.rst_n,
		.clk_en,
		.async_val(link.cell_in_transfer_clock),
		.sync_val(lclk)
	);
	cell_in_sync #(.W(PORT_SEL_BITS)) sel_sync (
		.ref_clk,
		.rst_n,
		.clk_en,
		.async_val(link.cell_in_port_select),
		.sync_val(sel)
	);
	cell_in_sync #(.W(1)) enb_sync (
		.ref_clk,
		.rst_n,
		.clk_en,
		.async_val(link.cell_in_enable_low),
		.sync_val(enb_n)
	);
	cell_in_sync #(.W(1)) soc_sync (
		.ref_clk,
		.rst_n,
		.clk_en,
		.async_val(link.cell_in_first_word_flag),
		.sync_val(soc)
	);
	cell_in_sync #(.W(1)) par_sync (
		.ref_clk,
		.rst_n,
		.clk_en,
		.async_val(link.cell_in_parity_bit),
		.sync_val(par)
	);
	cell_in_sync #(.W(WIDE_BITS)) word_sync (
		.ref_clk,
		.rst_n,
		.clk_en,
		.async_val(link.cell_in_word_bus),
		.sync_val(w)
	);
	assign rise = lclk && !q.clk_old;
	assign cell_len = wide_mode ? CELL_CNT_BITS'(CELL_WORDS_WIDE) :
		CELL_CNT_BITS'(CELL_BYTES_NARROW);
	assign take = rise && !enb_n && sel == my_port;
	assign start = take && soc;
	assign last = q.cnt == cell_len - 1'b1;
	assign push = take && (start || q.in_cell);
	assign entry = {start, last && !start,
		wide_mode ? w : {8'h00, w[NARROW_BITS-1:0]}};
	assign {out_first, out_last, out_word} = head;
	assign parity_err = q.perr;
	assign overflow = q.ovf;
	cell_in_pair_buf #(.W(ENT), .DEPTH(DEPTH)) out_buf (
		.ref_clk,
		.rst_n,
		.clk_en,
		.fill_data(entry),
		.fill_valid(push),
		.fill_ready(room),
		.head_data(head),
		.head_valid(out_valid),
		.head_ready(out_ready)
	);
	always_comb begin
		d = q;
		if (clk_en) begin
			d.clk_old = lclk;
			if (start) begin
				d.in_cell = 1'b1;
				d.cnt = CELL_CNT_BITS'(1);
			end else if (push) begin
				if (last) begin
					d.in_cell = 1'b0;
					d.cnt = '0;
				end else begin
					d.cnt = q.cnt + 1'b1;
				end
			end
			if (parity_err_clear) begin
				d.perr = 1'b0;
				d.ovf = 1'b0;
			end
			if (push && ((^entry[WIDE_BITS-1:0]) ^ odd_parity) != par) begin
				d.perr = 1'b1;
			end
			// A word that finds the buffer full is lost; the sticky flag reports it.
			if (push && !room) begin
				d.ovf = 1'b1;
			end
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule // cell_in_phy

module cell_in_sync #(
	parameter int W = 1
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [W-1:0] async_val,
	output logic [W-1:0] sync_val
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_t;
	sync_t q, d;
	assign sync_val = q.s2;
	always_comb begin
		d = q;
		if (clk_en) begin
			d.s1 = async_val;
			d.s2 = q.s1;
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule // cell_in_sync

module cell_in_pair_buf #(
	parameter int W = 18,
	parameter int DEPTH = 2
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [W-1:0] fill_data,
	input wire logic fill_valid,
	output logic fill_ready,
	output logic [W-1:0] head_data,
	output logic head_valid,
	input wire logic head_ready
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0] rd;
		logic [PW-1:0] wr;
		logic [CW-1:0] cnt;
	} pbuf_t;
	pbuf_t q, d;
	logic push, pop;
	// No handshake completes while frozen, so no word is lost or repeated.
	assign head_valid = clk_en && q.cnt != '0;
	assign fill_ready = clk_en && (q.cnt != CW'(DEPTH) || head_ready);
	assign push = fill_valid && fill_ready;
	assign pop = head_valid && head_ready;
	assign head_data = q.mem[q.rd];
	always_comb begin
		d = q;
		if (clk_en) begin
			if (push) begin
				d.mem[q.wr] = fill_data;
				d.wr = (q.wr == PW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
			end
			if (pop) begin
				d.rd = (q.rd == PW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
			end
			d.cnt = q.cnt + CW'(push) - CW'(pop);
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule // cell_in_pair_buf

/* sim/cell_in_chk.sv */
`timescale 1ns/1ps
module cell_in_chk (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic cell_in_transfer_clock,
	input wire logic [15:0] cell_in_word_bus,
	input wire logic cell_in_parity_bit,
	input wire logic cell_in_first_word_flag,
	input wire logic cell_in_enable_low
);
	wire c = cell_in_transfer_clock;
	wire e = cell_in_enable_low;
	wire s = cell_in_first_word_flag;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence high4; c [*4] ##1 !c; endsequence
	AST_CLK_HIGH: assert property ($rose(c) |-> high4) else $error("clk high");
	AST_CLK_LOW: assert property ($fell(c) |-> !c [*3]) else $error("clk low");
	AST_EN_EDGE: assert property ($changed(e) |-> !c [*2]) else $error("en edge");
	AST_EN_HOLD: assert property ($fell(e) |-> !e [*8]) else $error("en hold");
	AST_SOC_EN: assert property (s |-> !e) else $error("soc en");
	AST_SOC_HOLD: assert property ($rose(s) |-> s [*8]) else $error("soc hold");
	AST_WORD: assert property ($changed(cell_in_word_bus) |-> !c) else $error("word");
	AST_PAR: assert property ($rose(c) |-> $stable(cell_in_parity_bit) [*4]) else $error("par");
endmodule // cell_in_chk

/* sim/tb.sv */
`timescale 1ns/1ps
module tb;
	import cell_in_pkg::*;
	// Row: wide, master odd, phy odd, expected parity error, master port.
	logic [8:0] rows [5] = '{9'h1D5, 9'h015, 9'h115, 9'h1B5, 9'h1C3};
	logic ref_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, ce2 = 1'b1, clr = 1'b0, rdy = 1'b1;
	logic wide = 1'b1, modd = 1'b1, podd = 1'b1, src_first = 1'b0, src_valid = 1'b0;
	logic src_ready, perr, vld, fst, lst, ov2, ovf2;
	logic [4:0] sel = 5'h15, port = 5'h15;
	logic [15:0] src_word = 16'h0000, word;
	logic [17:0] exp_q[$];
	int errors = 0, n_tests = 0, n2 = 0;
	cell_in_if l1();
	cell_in_if l2();
	always #50 ref_clk = ~ref_clk;
	cell_in_master cell_in_master_inst (.ref_clk, .rst_n, .clk_en(ce), .link(l1.master),
		.wide_mode(wide), .odd_parity(modd), .port_select(sel), .src_word, .src_first,
		.src_valid, .src_ready);
	cell_in_phy cell_in_phy_inst (.ref_clk, .rst_n, .clk_en(ce), .link(l1.phy),
		.wide_mode(wide), .odd_parity(podd), .my_port(port), .parity_err_clear(clr),
		.parity_err(perr), .out_word(word), .out_first(fst), .out_last(lst),
		.out_valid(vld), .out_ready(rdy), .overflow());
	cell_in_phy cell_in_phy_inst2 (.ref_clk, .rst_n, .clk_en(ce2), .link(l2.phy),
		.wide_mode(wide), .odd_parity(podd), .my_port(port), .parity_err_clear(clr),
		.parity_err(), .out_word(), .out_first(), .out_last(), .out_valid(ov2),
		.out_ready(rdy), .overflow(ovf2));
	cell_in_chk cell_in_chk_inst (.ref_clk, .rst_n,
		.cell_in_transfer_clock(l1.cell_in_transfer_clock),
		.cell_in_word_bus(l1.cell_in_word_bus),
		.cell_in_parity_bit(l1.cell_in_parity_bit),
		.cell_in_first_word_flag(l1.cell_in_first_word_flag),
		.cell_in_enable_low(l1.cell_in_enable_low));
	task chk(input logic [17:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task end_sim;
		if (errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task send(input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge ref_clk);
			src_valid = 1'b1;
			src_first = i == 0;
			src_word = 16'hA500 + 16'(i);
			do @(posedge ref_clk); while (src_ready !== 1'b1);
			if (sel == port)
				exp_q.push_back({i == 0, i == n - 1, wide ? src_word : {8'h00, src_word[7:0]}});
		end
		@(negedge ref_clk);
		src_valid = 1'b0;
	endtask
	// Second link: the bench plays the master, 800 ns per word.
	task lw(input logic e, s, input int n);
		repeat (n) begin
			l2.cell_in_enable_low = e;
			l2.cell_in_first_word_flag = s;
			l2.cell_in_word_bus = l2.cell_in_word_bus + 16'h0101;
			l2.cell_in_parity_bit = ~^l2.cell_in_word_bus;
			repeat (4) @(negedge ref_clk);
			l2.cell_in_transfer_clock = 1'b1;
			repeat (4) @(negedge ref_clk);
			l2.cell_in_transfer_clock = 1'b0;
		end
	endtask
	always @(posedge ref_clk) begin
		if ((vld & rdy) === 1'b1)
			chk({fst, lst, word}, exp_q.size() > 0 ? exp_q.pop_front() : 18'h3FFFF);
		if ((ov2 & rdy) === 1'b1)
			n2++;
	end
	initial begin
		{l2.cell_in_transfer_clock, l2.cell_in_enable_low, l2.cell_in_first_word_flag} = 3'h2;
		{l2.cell_in_word_bus, l2.cell_in_parity_bit} = 17'h00001;
		l2.cell_in_port_select = 5'h15;
		repeat (20) @(negedge ref_clk);
		rst_n = 1'b1;
		foreach (rows[k]) begin
			{wide, modd, podd} = rows[k][8:6];
			sel = rows[k][4:0];
			send(wide ? CELL_WORDS_WIDE : CELL_BYTES_NARROW);
			repeat (20) @(negedge ref_clk);
			chk(18'(exp_q.size()), 18'h00000);
			chk(18'(perr), 18'(rows[k][5]));
			clr = 1'b1;
			@(negedge ref_clk);
			clr = 1'b0;
		end
		lw(1'b0, 1'b0, 2);
		lw(1'b0, 1'b1, 1);
		lw(1'b1, 1'b0, 1);
		lw(1'b0, 1'b0, 27);
		repeat (10) @(negedge ref_clk);
		chk(18'(n2), 18'(CELL_WORDS_WIDE));
		rdy = 1'b0;
		lw(1'b0, 1'b1, 4);
		chk(18'(ovf2), 18'h00001);
		@(negedge ref_clk);
		rdy = 1'b1;
		repeat (10) @(negedge ref_clk);
		chk(18'(n2), 18'(CELL_WORDS_WIDE + 2));
		// A frozen receiver takes nothing from its link.
		ce2 = 1'b0;
		lw(1'b0, 1'b1, 3);
		ce2 = 1'b1;
		repeat (10) @(negedge ref_clk);
		chk(18'(n2), 18'(CELL_WORDS_WIDE + 2));
		// Reset in mid-run clears the sticky flags and idles the link.
		rst_n = 1'b0;
		repeat (2) @(negedge ref_clk);
		chk(18'({ovf2, ov2, vld, perr, l1.cell_in_enable_low, l1.cell_in_transfer_clock}),
			18'h00002);
		rst_n = 1'b1;
		sel = port;
		send(CELL_WORDS_WIDE);
		repeat (20) @(negedge ref_clk);
		chk(18'(exp_q.size()), 18'h00000);
		chk(18'(perr), 18'h00000);
		end_sim();
	end
	initial begin
		#2000000;
		errors++;
		end_sim();
	end
endmodule // tb
